// ===== hw/nv_seq_consts.vh
`ifndef NV_SEQ_CONSTS_VH
`define NV_SEQ_CONSTS_VH

// Core clock rate in MHz.
`define CLK_MHZ 250

// Time figures in their own units.
`define RESTORE_HV_MS 20
`define RESTORE_LV_MS 40
`define SAVE_MS 8
`define WRITE_FINISH_NS 25
`define CMD_RESTORE_US 600
`define SPECIAL_CMD_US 500
`define WAKE_HV_MS 20
`define WAKE_LV_MS 40
`define SLEEP_ENTRY_MS 8
`define STANDBY_ENTRY_US 100
`define RESUME_AFTER_PIN_HIGH_US 5
`define PIN_ACTIVE_HIGH_NS 500

// Cycle counts at the core clock rate, sized to the duration counter.
// Every figure is a maximum and so rounds down.
`define RESTORE_HV_CYC 24'h4C4B40
`define RESTORE_LV_CYC 24'h989680
`define SAVE_CYC 24'h1E8480
`define WRITE_FINISH_CYC 24'h000006
`define CMD_RESTORE_CYC 24'h0249F0
`define SPECIAL_CMD_CYC 24'h01E848
`define WAKE_HV_CYC 24'h4C4B40
`define WAKE_LV_CYC 24'h989680
`define SLEEP_ENTRY_CYC 24'h1E8480
`define STANDBY_ENTRY_CYC 24'h0061A8
`define RESUME_CYC 24'h0004E2
`define PIN_ACTIVE_HIGH_CYC 24'h00007D

// Width of the shared duration counter, sized for the longest time.
`define TIMER_W 24

// Reset value of the power-fail save enable.
`define PF_SAVE_EN_RST 1'b1

`endif

// ===== hw/pin_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for a group of asynchronous level inputs.
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] asyncIn,
  input  wire [WIDTH-1:0] resetValue,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;  // First stage, read only by the second.
  reg [WIDTH-1:0] stage2_q;  // Second stage, safe for logic.

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Each bit passes two flops; reset loads the safe idle level.
      always @(posedge core_clk) begin
        if (reset) begin
          stage1_q[i] <= resetValue[i];
          stage2_q[i] <= resetValue[i];
        end else begin
          stage1_q[i] <= asyncIn[i];
          stage2_q[i] <= stage1_q[i];
        end
      end
    end
  endgenerate

  // Only the second stage is seen by the logic.
  assign syncOut = stage2_q;

endmodule

// ===== hw/duration_timer.v
`timescale 1ns/1ps
`include "nv_seq_consts.vh"
// Down counter that measures one duration and pulses when it runs out.
module duration_timer (
  input  wire                  core_clk,
  input  wire                  reset,
  input  wire                  load,
  input  wire [`TIMER_W-1:0]   loadValue,
  output reg                   expired
);

  reg [`TIMER_W-1:0] count_q;  // Cycles left in the running duration.

  // A load restarts the count; the pulse stands in the last cycle of the
  // duration, so a state that leaves on it lasts exactly loadValue cycles.
  always @(posedge core_clk) begin
    if (reset) begin
      count_q <= {`TIMER_W{1'b0}};
      expired <= 1'b0;
    end else if (load) begin
      count_q <= loadValue - 1'b1;
      expired <= (loadValue == {{(`TIMER_W-1){1'b0}}, 1'b1});
    end else if (count_q != {`TIMER_W{1'b0}}) begin
      count_q <= count_q - 1'b1;
      expired <= (count_q == {{(`TIMER_W-1){1'b0}}, 1'b1});
    end else begin
      expired <= 1'b0;
    end
  end

endmodule

// ===== hw/nv_store_recall_sequencer.v
`timescale 1ns/1ps
`include "nv_seq_consts.vh"
module nv_store_recall_sequencer #(
  parameter [`TIMER_W-1:0] RESTORE_HV_CYCLES = `RESTORE_HV_CYC,
  parameter [`TIMER_W-1:0] RESTORE_LV_CYCLES = `RESTORE_LV_CYC,
  parameter [`TIMER_W-1:0] SAVE_CYCLES       = `SAVE_CYC,
  parameter [`TIMER_W-1:0] CMD_RESTORE_CYCLES = `CMD_RESTORE_CYC,
  parameter [`TIMER_W-1:0] SPECIAL_CYCLES    = `SPECIAL_CMD_CYC,
  parameter [`TIMER_W-1:0] WAKE_HV_CYCLES    = `WAKE_HV_CYC,
  parameter [`TIMER_W-1:0] WAKE_LV_CYCLES    = `WAKE_LV_CYC,
  parameter [`TIMER_W-1:0] SLEEP_CYCLES      = `SLEEP_ENTRY_CYC,
  parameter [`TIMER_W-1:0] STANDBY_CYCLES    = `STANDBY_ENTRY_CYC
) (
  input  wire core_clk,
  input  wire reset,
  input  wire supplyOk,
  input  wire lowVoltVariant,
  input  wire chipSelectN,
  input  wire saveRequestBusyPinIn,
  output reg  saveRequestBusyPinOut_q,
  output reg  saveRequestBusyPinOe_q,
  input  wire sramWriteSeen,
  input  wire cmdSave,
  input  wire cmdRestore,
  input  wire cmdPfSaveEnable,
  input  wire cmdPfSaveDisable,
  input  wire cmdSleep,
  output reg  hostAccessEn_q,
  output reg  sramAccessEn_q,
  output reg  saveActive_q,
  output reg  restoreActive_q,
  output reg  sleeping_q,
  output reg  standby_q,
  output reg  powerFailSaveEn_q
);

  // Sequencer states.
  localparam [3:0] ST_OFF      = 4'h0;  // Supply below trigger level.
  localparam [3:0] ST_PU_REST  = 4'h1;  // Power-up restore running.
  localparam [3:0] ST_IDLE     = 4'h2;  // Normal operation.
  localparam [3:0] ST_DELAY    = 4'h3;  // Write-finish window at start.
  localparam [3:0] ST_SAVE     = 4'h4;  // Save to nonvolatile cells.
  localparam [3:0] ST_RESTORE  = 4'h5;  // Command restore.
  localparam [3:0] ST_RELEASE  = 4'h6;  // Pin driven high, then freed.
  localparam [3:0] ST_SPECIAL  = 4'h7;  // Enable/disable being applied.
  localparam [3:0] ST_SLP_ENT  = 4'h8;  // Entering sleep.
  localparam [3:0] ST_ASLEEP   = 4'h9;  // Sleeping.
  localparam [3:0] ST_WAKE     = 4'hA;  // Waking from sleep.
  localparam [3:0] ST_PIN_WAIT = 4'hB;  // Waiting for pin to go high.

  // Kinds of operation that pass through the write-finish window.
  localparam [2:0] OP_CMD_SAVE  = 3'h0;
  localparam [2:0] OP_CMD_REST  = 3'h1;
  localparam [2:0] OP_PF_EN     = 3'h2;
  localparam [2:0] OP_PF_DIS    = 3'h3;
  localparam [2:0] OP_PIN_SAVE  = 3'h4;
  localparam [2:0] OP_AUTO_SAVE = 3'h5;

  localparam [`TIMER_W-1:0] DELAY_CYCLES = `WRITE_FINISH_CYC;
  localparam [`TIMER_W-1:0] HIGH_CYCLES  = `PIN_ACTIVE_HIGH_CYC;

  reg  [3:0]          state_q;        // Current sequencer state.
  reg  [3:0]          state_d;        // Next sequencer state.
  reg  [2:0]          opKind_q;       // Operation latched at its start.
  reg  [2:0]          opKind_d;       // Next operation kind.
  reg                 dirty_q;        // SRAM written since last nv cycle.
  reg                 clearDirty;     // A save or restore starts, or power-up restore ends.
  reg                 pfEn_d;         // Next power-fail save enable.
  reg                 timerLoad;      // Start a new duration.
  reg  [`TIMER_W-1:0] timerValue;     // Length of that duration.
  wire                timerDone;      // Current duration has elapsed.
  wire [3:0]          syncIn;         // Synchronised pin levels.
  wire                supplyOkS;      // Supply above trigger level.
  wire                lowVoltS;       // Lowest-voltage variant strap.
  wire                csNS;           // Chip select, active low.
  wire                pinInS;         // Save-request/busy pin level.
  reg                 csPrev_q;       // Chip select one cycle earlier.

  // Every pin input passes two flops before use. Supply reads as low
  // until it has really been seen, so reset never starts a restore.
  pin_sync #(
    .WIDTH      (4)
  ) u_pin_sync (
    .core_clk   (core_clk),
    .reset      (reset),
    .asyncIn    ({supplyOk, lowVoltVariant, chipSelectN,
                  saveRequestBusyPinIn}),
    .resetValue (4'h3),
    .syncOut    (syncIn)
  );

  assign supplyOkS = syncIn[3];
  assign lowVoltS  = syncIn[2];
  assign csNS      = syncIn[1];
  assign pinInS    = syncIn[0];

  // One shared counter times every bounded duration.
  duration_timer u_timer (
    .core_clk  (core_clk),
    .reset     (reset),
    .load      (timerLoad),
    .loadValue (timerValue),
    .expired   (timerDone)
  );

  // Selects a duration that depends on the supply variant.
  function [`TIMER_W-1:0] variantTime;
    input                lowVolt;
    input [`TIMER_W-1:0] hvTime;
    input [`TIMER_W-1:0] lvTime;
    begin
      variantTime = lowVolt ? lvTime : hvTime;
    end
  endfunction

  // Next-state logic for the sequencer.
  always @* begin
    state_d    = state_q;
    opKind_d   = opKind_q;
    pfEn_d     = powerFailSaveEn_q;
    timerLoad  = 1'b0;
    timerValue = DELAY_CYCLES;
    clearDirty = 1'b0;
    case (state_q)
      ST_OFF: begin
        // Supply back above trigger: restore, bounded by variant time.
        if (supplyOkS) begin
          state_d    = ST_PU_REST;
          timerLoad  = 1'b1;
          timerValue = variantTime(lowVoltS, RESTORE_HV_CYCLES,
                                   RESTORE_LV_CYCLES);
        end
      end
      ST_PU_REST: begin
        // Host stays locked out until the restore time has run.
        if (!supplyOkS) begin
          state_d = ST_OFF;
        end else if (timerDone) begin
          state_d    = ST_RELEASE;
          clearDirty = 1'b1;
          timerLoad  = 1'b1;
          timerValue = HIGH_CYCLES;
        end
      end
      ST_IDLE: begin
        // Supply loss has top priority, then the pin, then commands.
        timerLoad  = 1'b1;
        timerValue = DELAY_CYCLES;
        if (!supplyOkS) begin
          state_d  = ST_DELAY;
          opKind_d = OP_AUTO_SAVE;
        end else if (!pinInS) begin
          state_d  = ST_DELAY;
          opKind_d = OP_PIN_SAVE;
        end else if (cmdSave) begin
          state_d  = ST_DELAY;
          opKind_d = OP_CMD_SAVE;
        end else if (cmdRestore) begin
          state_d  = ST_DELAY;
          opKind_d = OP_CMD_REST;
        end else if (cmdPfSaveEnable) begin
          state_d  = ST_DELAY;
          opKind_d = OP_PF_EN;
        end else if (cmdPfSaveDisable) begin
          state_d  = ST_DELAY;
          opKind_d = OP_PF_DIS;
        end else if (cmdSleep) begin
          state_d    = ST_SLP_ENT;
          timerValue = SLEEP_CYCLES;
        end else begin
          timerLoad = 1'b0;
        end
      end
      ST_DELAY: begin
        // After the write-finish window, dispatch the operation.
        if (timerDone) begin
          timerLoad = 1'b1;
          case (opKind_q)
            OP_CMD_REST: begin
              state_d    = ST_RESTORE;
              clearDirty = 1'b1;
              timerValue = CMD_RESTORE_CYCLES;
            end
            OP_PF_EN, OP_PF_DIS: begin
              state_d    = ST_SPECIAL;
              pfEn_d     = (opKind_q == OP_PF_EN);
              timerValue = SPECIAL_CYCLES;
            end
            OP_CMD_SAVE: begin
              state_d    = ST_SAVE;
              clearDirty = 1'b1;
              timerValue = SAVE_CYCLES;
            end
            OP_AUTO_SAVE: begin
              // Only a dirty array with the save enabled is saved.
              if (dirty_q && powerFailSaveEn_q) begin
                state_d    = ST_SAVE;
                clearDirty = 1'b1;
                timerValue = SAVE_CYCLES;
              end else begin
                state_d   = ST_OFF;
                timerLoad = 1'b0;
              end
            end
            default: begin
              // Pin request: a clean array skips the save.
              if (dirty_q) begin
                state_d    = ST_SAVE;
                clearDirty = 1'b1;
                timerValue = SAVE_CYCLES;
              end else begin
                state_d   = ST_PIN_WAIT;
                timerLoad = 1'b0;
              end
            end
          endcase
        end
      end
      ST_SAVE, ST_RESTORE: begin
        // Busy until the bounded duration has expired.
        if (timerDone) begin
          timerLoad  = 1'b1;
          timerValue = HIGH_CYCLES;
          state_d    = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Pin driven high for a bounded time, then released.
        if (timerDone) begin
          state_d = ST_PIN_WAIT;
        end
      end
      ST_SPECIAL: begin
        // New enable setting takes hold before the bound runs out.
        if (timerDone) begin
          state_d = ST_PIN_WAIT;
        end
      end
      ST_PIN_WAIT: begin
        // Resume once supply is good and nobody holds the pin low.
        if (!supplyOkS) begin
          state_d = ST_OFF;
        end else if (pinInS) begin
          state_d = ST_IDLE;
        end
      end
      ST_SLP_ENT: begin
        if (timerDone) begin
          state_d = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        // Selecting the chip wakes it; wake time depends on variant.
        if (!supplyOkS) begin
          state_d = ST_OFF;
        end else if (!csNS && csPrev_q) begin
          state_d    = ST_WAKE;
          timerLoad  = 1'b1;
          timerValue = variantTime(lowVoltS, WAKE_HV_CYCLES,
                                   WAKE_LV_CYCLES);
        end
      end
      ST_WAKE: begin
        if (timerDone) begin
          state_d = ST_PIN_WAIT;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    // Supply loss during a save lets the save finish; during a restore,
    // special command, wake or sleep entry it drops straight to the off state.
    if (!supplyOkS && (state_q == ST_RESTORE || state_q == ST_SPECIAL ||
                       state_q == ST_WAKE || state_q == ST_SLP_ENT)) begin
      state_d   = ST_OFF;
      timerLoad = 1'b0;
    end
  end

  // State, operation kind and sampled pin history.
  always @(posedge core_clk) begin
    if (reset) begin
      state_q   <= ST_OFF;
      opKind_q  <= OP_CMD_SAVE;
      csPrev_q  <= 1'b1;
    end else begin
      state_q   <= state_d;
      opKind_q  <= opKind_d;
      csPrev_q  <= csNS;
    end
  end

  // Dirty flag: a write in the clearing cycle keeps it set.
  always @(posedge core_clk) begin
    if (reset) begin
      dirty_q <= 1'b0;
    end else if (sramWriteSeen) begin
      dirty_q <= 1'b1;
    end else if (clearDirty) begin
      dirty_q <= 1'b0;
    end
  end

  // Power-fail save enable, changed only by its special commands.
  always @(posedge core_clk) begin
    if (reset) begin
      powerFailSaveEn_q <= `PF_SAVE_EN_RST;
    end else begin
      powerFailSaveEn_q <= pfEn_d;
    end
  end

  // Standby is entered on deselect while idle, well inside its bound.
  always @(posedge core_clk) begin
    if (reset) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= (state_d == ST_IDLE) && csNS;
    end
  end

  // Outputs registered from the next state so they track it exactly.
  always @(posedge core_clk) begin
    if (reset) begin
      hostAccessEn_q          <= 1'b0;
      sramAccessEn_q          <= 1'b0;
      saveActive_q            <= 1'b0;
      restoreActive_q         <= 1'b0;
      sleeping_q              <= 1'b0;
      saveRequestBusyPinOut_q <= 1'b1;
      saveRequestBusyPinOe_q  <= 1'b0;
    end else begin
      // Host cycles pass only in normal operation with good supply.
      hostAccessEn_q  <= (state_d == ST_IDLE) && supplyOkS;
      // SRAM stays on through the write window; a low pin blocks it.
      sramAccessEn_q  <= (state_d == ST_DELAY) ||
                         ((state_d == ST_IDLE) && pinInS);
      saveActive_q    <= (state_d == ST_SAVE);
      restoreActive_q <= (state_d == ST_RESTORE) ||
                         (state_d == ST_PU_REST);
      sleeping_q      <= (state_d == ST_ASLEEP);
      // Pin is pulled low while busy, driven high briefly, then freed.
      if (state_d == ST_SAVE || state_d == ST_RESTORE ||
          state_d == ST_PU_REST) begin
        saveRequestBusyPinOut_q <= 1'b0;
        saveRequestBusyPinOe_q  <= 1'b1;
      end else if (state_d == ST_RELEASE) begin
        saveRequestBusyPinOut_q <= 1'b1;
        saveRequestBusyPinOe_q  <= 1'b1;
      end else begin
        saveRequestBusyPinOut_q <= 1'b1;
        saveRequestBusyPinOe_q  <= 1'b0;
      end
    end
  end

endmodule

// ===== verification/nv_seq_pin_partner.sv
`timescale 1ns/1ps
// Outside party on the shared save-request/busy line.
module nv_seq_pin_partner (
  input  wire core_clk,
  input  wire pinOut,
  input  wire pinOe,
  output wire pinLevel
);
  // High while this party pulls the line low.
  reg pullLow;

  // Any low driver wins; otherwise the pull-up holds the line high.
  assign pinLevel = (pinOe ? pinOut : 1'b1) & ~pullLow;

  initial pullLow = 1'b0;

  // Asks for a save by holding the line low for n whole cycles.
  task request(input integer n);
    @(posedge core_clk);
    #1;
    pullLow = 1'b1;
    repeat (n) @(posedge core_clk);
    #1;
    pullLow = 1'b0;
  endtask
endmodule

// ===== verification/nv_seq_checker.sv
`timescale 1ns/1ps
`include "nv_seq_consts.vh"
// Watches the sequencer ports for timing and lock-out slips.
module nv_seq_checker #(
  parameter [`TIMER_W-1:0] RESTORE_HV_CYCLES = `RESTORE_HV_CYC,
  parameter [`TIMER_W-1:0] RESTORE_LV_CYCLES = `RESTORE_LV_CYC,
  parameter [`TIMER_W-1:0] SAVE_CYCLES       = `SAVE_CYC
) (
  input wire core_clk,
  input wire reset,
  input wire lowVoltVariant,
  input wire chipSelectN,
  input wire saveRequestBusyPinIn,
  input wire saveRequestBusyPinOut_q,
  input wire saveRequestBusyPinOe_q,
  input wire supplyOk,
  input wire cmdSave,
  input wire cmdRestore,
  input wire hostAccessEn_q,
  input wire sramAccessEn_q,
  input wire saveActive_q,
  input wire restoreActive_q,
  input wire sleeping_q,
  input wire standby_q
);
  // Lengths of the running save, restore and pin-high phases.
  reg [`TIMER_W-1:0] saveCnt;
  reg [`TIMER_W-1:0] restCnt;
  reg [7:0]          highCnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Counts cycles of each phase and clears when the phase ends.
  always @(posedge core_clk) begin
    if (reset) begin
      saveCnt <= {`TIMER_W{1'b0}};
      restCnt <= {`TIMER_W{1'b0}};
      highCnt <= 8'h00;
    end else begin
      saveCnt <= saveActive_q ? saveCnt + 1'b1 : {`TIMER_W{1'b0}};
      restCnt <= restoreActive_q ? restCnt + 1'b1 : {`TIMER_W{1'b0}};
      highCnt <= (saveRequestBusyPinOe_q && saveRequestBusyPinOut_q) ?
                 highCnt + 8'h01 : 8'h00;
    end
  end

  host_block_a: assert property
    ((saveActive_q || restoreActive_q) |-> !hostAccessEn_q)
    else $error("host access open during an operation");
  pin_low_a: assert property
    ((!saveRequestBusyPinIn)[*8] ##1 (!saveRequestBusyPinIn)[*4]
     |-> !sramAccessEn_q)
    else $error("array enabled while the line is low");
  write_window_a: assert property
    (cmdSave && hostAccessEn_q ##1 !hostAccessEn_q
     |-> sramAccessEn_q[*6] ##1 !sramAccessEn_q)
    else $error("array enable window wrong at save start");
  cmd_taken_a: assert property
    (cmdRestore && hostAccessEn_q
     |=> !hostAccessEn_q ##[1:12] restoreActive_q)
    else $error("restore command not acted on");
  save_len_a: assert property
    ($fell(saveActive_q) |-> saveCnt <= SAVE_CYCLES)
    else $error("save ran too long");
  rest_len_a: assert property
    ($fell(restoreActive_q) |-> restCnt <=
     (lowVoltVariant ? RESTORE_LV_CYCLES : RESTORE_HV_CYCLES))
    else $error("restore ran too long");
  pin_high_a: assert property (highCnt <= 8'h7D)
    else $error("line driven high too long");
  standby_a: assert property
    ((chipSelectN && hostAccessEn_q)[*4] |-> standby_q)
    else $error("standby not entered");
  resume_a: assert property
    ($rose(saveRequestBusyPinIn) && supplyOk && !saveRequestBusyPinOe_q
     |-> ##[1:16] (hostAccessEn_q || saveActive_q))
    else $error("no resume after the line rose");

  save_c: cover property ($rose(saveActive_q));
  restore_c: cover property ($rose(restoreActive_q));
  sleep_c: cover property ($rose(sleeping_q));
endmodule

bind nv_store_recall_sequencer nv_seq_checker #(
  .RESTORE_HV_CYCLES(RESTORE_HV_CYCLES),
  .RESTORE_LV_CYCLES(RESTORE_LV_CYCLES),
  .SAVE_CYCLES(SAVE_CYCLES)) i_nv_seq_checker (
  .core_clk(core_clk), .reset(reset), .lowVoltVariant(lowVoltVariant),
  .chipSelectN(chipSelectN), .saveRequestBusyPinIn(saveRequestBusyPinIn),
  .saveRequestBusyPinOut_q(saveRequestBusyPinOut_q),
  .saveRequestBusyPinOe_q(saveRequestBusyPinOe_q), .supplyOk(supplyOk),
  .cmdSave(cmdSave), .cmdRestore(cmdRestore),
  .hostAccessEn_q(hostAccessEn_q), .sramAccessEn_q(sramAccessEn_q),
  .saveActive_q(saveActive_q), .restoreActive_q(restoreActive_q),
  .sleeping_q(sleeping_q), .standby_q(standby_q));

// ===== verification/nv_store_recall_sequencer_test.sv
`timescale 1ns/1ps
// Self-checking bench for the store and recall sequencer.
module nv_store_recall_sequencer_test;
  // Shortened durations in cycles.
  localparam integer RHV = 30, RLV = 40, SAV = 40, CRS = 20, SPC = 25;
  localparam integer WHV = 30, WLV = 40, SLP = 35;
  reg     core_clk, reset, supplyOk, lowVoltVariant, chipSelectN;
  reg     sramWriteSeen, cmdSave, cmdRestore, cmdPfSaveEnable;
  reg     cmdPfSaveDisable, cmdSleep;
  wire    pinOut, pinOe, pinLevel, hostEn, sramEn, saveAct, restAct;
  wire    sleeping, standby, pfEn;
  integer fail_count, total_checks, saveLen, restLen, n;

  nv_store_recall_sequencer #(.RESTORE_HV_CYCLES(RHV),
    .RESTORE_LV_CYCLES(RLV), .SAVE_CYCLES(SAV), .CMD_RESTORE_CYCLES(CRS),
    .SPECIAL_CYCLES(SPC), .WAKE_HV_CYCLES(WHV), .WAKE_LV_CYCLES(WLV),
    .SLEEP_CYCLES(SLP)) i_nv_store_recall_sequencer (
    .core_clk(core_clk), .reset(reset), .supplyOk(supplyOk),
    .lowVoltVariant(lowVoltVariant), .chipSelectN(chipSelectN),
    .saveRequestBusyPinIn(pinLevel), .saveRequestBusyPinOut_q(pinOut),
    .saveRequestBusyPinOe_q(pinOe), .sramWriteSeen(sramWriteSeen),
    .cmdSave(cmdSave), .cmdRestore(cmdRestore),
    .cmdPfSaveEnable(cmdPfSaveEnable), .cmdPfSaveDisable(cmdPfSaveDisable),
    .cmdSleep(cmdSleep), .hostAccessEn_q(hostEn), .sramAccessEn_q(sramEn),
    .saveActive_q(saveAct), .restoreActive_q(restAct),
    .sleeping_q(sleeping), .standby_q(standby), .powerFailSaveEn_q(pfEn));

  nv_seq_pin_partner i_nv_seq_pin_partner (.core_clk(core_clk),
    .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

  // Free-running 250 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Measures how long each operation stays active.
  always @(posedge core_clk) begin
    if (saveAct === 1'b1) saveLen = saveLen + 1;
    if (restAct === 1'b1) restLen = restLen + 1;
  end

  // Prints the verdict and stops the run.
  task conclude;
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task check(input string what, input [31:0] seen, input [31:0] want);
    total_checks = total_checks + 1;
    if (seen !== want) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %0h seen %0h", what, want, seen);
    end
  endtask

  // Moves to just after the k-th next rising edge.
  task step(input integer k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // Chooses the output that a wait watches.
  function pick(input integer k);
    pick = (k == 0) ? hostEn : (k == 1) ? sleeping : saveAct;
  endfunction

  // Waits a bounded time for an output to go high; n holds the cycles.
  task waitFor(input integer k, input integer lim);
    n = 0;
    while (pick(k) !== 1'b1 && n < lim) begin
      step(1);
      n = n + 1;
    end
  endtask

  // Sends a one-cycle command pulse: 0 save .. 4 sleep.
  task cmd(input integer k);
    {cmdSleep, cmdPfSaveDisable, cmdPfSaveEnable, cmdRestore, cmdSave} =
      5'h01 << k;
    step(1);
    {cmdSleep, cmdPfSaveDisable, cmdPfSaveEnable, cmdRestore, cmdSave} =
      5'h00;
  endtask

  // Marks the array as written since the last stored copy.
  task dirty;
    sramWriteSeen = 1'b1;
    step(1);
    sramWriteSeen = 1'b0;
  endtask

  // Host is locked out until the supply is good, then restore runs.
  task powerUp;
    step(6);
    check("host en low supply", hostEn, 1'b0);
    supplyOk = 1'b1;
    restLen = 0;
    waitFor(0, RHV + 200);
    check("host en after restore", hostEn, 1'b1);
    check("restore length", restLen > 0 && restLen <= RHV, 1'b1);
    check("power-fail save enable", pfEn, 1'b1);
    step(4);
    check("standby", standby, 1'b1);
  endtask

  // Save command with a restore sent while busy, which must be dropped.
  task saveByCommand;
    saveLen = 0;
    cmd(0);
    check("host en at save", hostEn, 1'b0);
    check("array en at save", sramEn, 1'b1);
    step(10);
    restLen = 0;
    cmd(1);
    waitFor(0, SAV + 400);
    check("save length", saveLen > 0 && saveLen <= SAV, 1'b1);
    check("refused restore", restLen, 0);
  endtask

  // Restore command completes inside its limit.
  task restoreByCommand;
    restLen = 0;
    cmd(1);
    waitFor(0, CRS + 400);
    check("cmd restore length", restLen > 0 && restLen <= CRS, 1'b1);
  endtask

  // Power-fail save disable then enable.
  task specialCommands;
    cmd(3);
    waitFor(0, SPC + 200);
    check("special latency", n <= SPC + 10, 1'b1);
    check("power-fail save off", pfEn, 1'b0);
    cmd(2);
    waitFor(0, SPC + 200);
    check("power-fail save on", pfEn, 1'b1);
  endtask

  // Pin request with a clean array, then with a dirty one.
  task pinRequests;
    saveLen = 0;
    i_nv_seq_pin_partner.request(5);
    check("host en pin low", hostEn, 1'b0);
    waitFor(0, 1250);
    check("resume after pin", hostEn, 1'b1);
    check("clean pin save", saveLen, 0);
    dirty;
    i_nv_seq_pin_partner.request(5);
    waitFor(0, SAV + 400);
    check("dirty pin save", saveLen > 0 && saveLen <= SAV, 1'b1);
  endtask

  // Sleep entry, then wake on chip select.
  task sleepWake;
    cmd(4);
    waitFor(1, SLP + 200);
    check("sleep entry", n <= SLP + 10, 1'b1);
    chipSelectN = 1'b0;
    waitFor(0, WHV + 200);
    check("wake time", n <= WHV + 10, 1'b1);
    chipSelectN = 1'b1;
    step(4);
  endtask

  // Supply loss with a dirty array saves, then the longer restore runs.
  task supplyLoss;
    lowVoltVariant = 1'b1;
    dirty;
    saveLen = 0;
    supplyOk = 1'b0;
    step(4);
    check("host en supply lost", hostEn, 1'b0);
    step(SAV + 200);
    check("power-fail save", saveLen > 0 && saveLen <= SAV, 1'b1);
    supplyOk = 1'b1;
    restLen = 0;
    waitFor(0, RLV + 400);
    check("slow restore", restLen > RHV && restLen <= RLV, 1'b1);
  endtask

  // Cuts a hang short.
  initial begin
    #120000;
    fail_count = fail_count + 1;
    conclude;
  end

  // Main sequence.
  initial begin
    {fail_count, total_checks, saveLen, restLen, n} = 0;
    {reset, supplyOk, lowVoltVariant, chipSelectN} = 4'h9;
    {sramWriteSeen, cmdSave, cmdRestore} = 3'h0;
    {cmdPfSaveEnable, cmdPfSaveDisable, cmdSleep} = 3'h0;
    step(10);
    reset = 1'b0;
    powerUp;
    saveByCommand;
    restoreByCommand;
    specialCommands;
    pinRequests;
    sleepWake;
    supplyLoss;
    conclude;
  end
endmodule
